// [verilog/rtdpd_top.sv]
// parameter record decoder and value scaling for a four-channel resistance/rtd input module
`include "rtdpd_cfg.svh"
module rtdpd_top (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic PRM_WR,
   input wire logic [2:0] PRM_IDX,
   input wire logic [7:0] PRM_DATA,
   output logic [7:0] PRM_RDATA,
   input wire logic [3:0] RAW_VALID,
   input wire logic [3:0][15:0] RAW_DATA,
   input wire logic DIAG_CLR,
   output logic [3:0] VALUE_VALID,
   output logic [3:0][15:0] VALUE,
   output logic [3:0] CONV_EN,
   output rtdpd_pkg::rtdpd_wires_t [3:0] CH_WIRES,
   output logic [3:0] WIRE_CHECK_EN,
   output logic [1:0] TEMP_UNIT,
   output logic [1:0] MAINS_REJ,
   output logic DIAG_IRQ_EN,
   output logic DIAG_IRQ_REQ,
   output logic MOD_PARAM_ERR,
   output logic [3:0] DIAG_PARAM,
   output logic [3:0] DIAG_OVER,
   output logic [3:0] DIAG_UNDER,
   output logic [3:0] CH_LED
);

   logic [7:0] diag_interrupt_enable_reg;
   logic [7:0] open_wire_detect_enable_reg;
   logic [7:0] temperature_unit_select_reg;
   logic [7:0] mains_rejection_select_reg;
   logic [3:0][7:0] channel_range_select_reg;
   logic [3:0] ch_conv;
   logic [3:0] ch_perr;
   logic [3:0] ch_over;
   logic [3:0] ch_under;

   // write strobes per parameter byte
   wire wr_diag = PRM_WR && (PRM_IDX == `RTDPD_IDX_DIAG);
   wire wr_wire = PRM_WR && (PRM_IDX == `RTDPD_IDX_WIRE);
   wire wr_unit = PRM_WR && (PRM_IDX == `RTDPD_IDX_UNIT);
   wire wr_mains = PRM_WR && (PRM_IDX == `RTDPD_IDX_MAINS);
   wire wr_fn = PRM_WR && PRM_IDX[2];

   // R9: reserved bits dropped on write
   wire [7:0] wire_next = PRM_DATA & `RTDPD_WIRE_MASK;
   wire [7:0] low2_next = PRM_DATA & `RTDPD_LOW2_MASK;

   // readback of the selected parameter byte
   wire [7:0] rdata_next = PRM_IDX[2] ? channel_range_select_reg[PRM_IDX[1:0]] :
      (PRM_IDX == `RTDPD_IDX_DIAG) ? diag_interrupt_enable_reg :
      (PRM_IDX == `RTDPD_IDX_WIRE) ? open_wire_detect_enable_reg :
      (PRM_IDX == `RTDPD_IDX_UNIT) ? temperature_unit_select_reg : mains_rejection_select_reg;

   // R1: only the exact enable code opens the interrupt
   wire irq_en_next = (diag_interrupt_enable_reg == `RTDPD_DIAG_ON);
   wire [1:0] unit_code = temperature_unit_select_reg[1:0];
   wire [1:0] mains_code = mains_rejection_select_reg[1:0];

   // R9: module-wide parameterization faults
   wire diag_bad = (diag_interrupt_enable_reg != `RTDPD_DIAG_ON)
      && (diag_interrupt_enable_reg != `RTDPD_DIAG_OFF);
   wire unit_bad = (unit_code != `RTDPD_UNIT_C) && (unit_code != `RTDPD_UNIT_F)
      && (unit_code != `RTDPD_UNIT_K);
   wire mains_bad = (mains_code != `RTDPD_MAINS_60) && (mains_code != `RTDPD_MAINS_50);
   wire glob_err_next = diag_bad || unit_bad || mains_bad;

   // R8: sticky diagnostics, a new event wins over a clear in the same cycle
   wire [3:0] keep = ~{4{DIAG_CLR}};
   wire [3:0] perr_set = ch_perr | {4{MOD_PARAM_ERR}};
   wire [3:0] diag_param_next = (DIAG_PARAM & keep) | perr_set;
   wire [3:0] diag_over_next = (DIAG_OVER & keep) | ch_over;
   wire [3:0] diag_under_next = (DIAG_UNDER & keep) | ch_under;
   wire [3:0] new_err = (perr_set & ~DIAG_PARAM) | (ch_over & ~DIAG_OVER) | (ch_under & ~DIAG_UNDER);
   wire [3:0] led_next = diag_param_next | diag_over_next | diag_under_next;

   // parameter store; the head only sends diag and wire-break bytes at stop
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         diag_interrupt_enable_reg <= `RTDPD_RST_DIAG;
         open_wire_detect_enable_reg <= `RTDPD_RST_WIRE;
         temperature_unit_select_reg <= `RTDPD_RST_UNIT;
         mains_rejection_select_reg <= `RTDPD_RST_MAINS;
         channel_range_select_reg <= {4{`RTDPD_RST_FN}};
      end else begin
         // R7: no run-time interlock needed
         if (wr_diag) begin
            diag_interrupt_enable_reg <= PRM_DATA;
         end
         // R2: one bit per channel
         if (wr_wire) begin
            open_wire_detect_enable_reg <= wire_next;
         end
         // R3: unit field
         if (wr_unit) begin
            temperature_unit_select_reg <= low2_next;
         end
         // R4: suppression field
         if (wr_mains) begin
            mains_rejection_select_reg <= low2_next;
         end
         if (wr_fn) begin
            channel_range_select_reg[PRM_IDX[1:0]] <= PRM_DATA;
         end
      end
   end

   // decoded settings to the converter side
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         PRM_RDATA <= 8'h00;
         WIRE_CHECK_EN <= 4'h0;
         TEMP_UNIT <= `RTDPD_UNIT_C;
         MAINS_REJ <= `RTDPD_MAINS_50;
         DIAG_IRQ_EN <= 1'b0;
         MOD_PARAM_ERR <= 1'b0;
         CONV_EN <= 4'h0;
      end else begin
         PRM_RDATA <= rdata_next;
         WIRE_CHECK_EN <= open_wire_detect_enable_reg[3:0];
         TEMP_UNIT <= unit_code;
         MAINS_REJ <= mains_code;
         DIAG_IRQ_EN <= irq_en_next;
         MOD_PARAM_ERR <= glob_err_next;
         // a bad global setting stops every conversion rather than measure wrongly
         CONV_EN <= ch_conv & ~{4{glob_err_next}};
      end
   end

   // R8: diagnostic record and channel indicators
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         DIAG_PARAM <= 4'h0;
         DIAG_OVER <= 4'h0;
         DIAG_UNDER <= 4'h0;
         CH_LED <= 4'h0;
         DIAG_IRQ_REQ <= 1'b0;
      end else begin
         DIAG_PARAM <= diag_param_next;
         DIAG_OVER <= diag_over_next;
         DIAG_UNDER <= diag_under_next;
         CH_LED <= led_next;
         // R1: interrupt request only while enabled
         DIAG_IRQ_REQ <= DIAG_IRQ_EN && (|new_err);
      end
   end

   for (genvar i = 0; i < 4; i++) begin : g_ch
      rtdpd_chan u_chan (
         .clk(CLK),
         .rst_n(RST_N),
         .fn_code(channel_range_select_reg[i]),
         .unit(unit_code),
         .raw_valid(RAW_VALID[i]),
         .raw_data(RAW_DATA[i]),
         .conv_en(ch_conv[i]),
         .param_err(ch_perr[i]),
         .wires(CH_WIRES[i]),
         .value_valid(VALUE_VALID[i]),
         .value(VALUE[i]),
         .over(ch_over[i]),
         .under(ch_under[i])
      );
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);

   a_irq_enable: // R1
   assert property (wr_diag && PRM_DATA == `RTDPD_DIAG_ON |-> ##2 DIAG_IRQ_EN)
   else $error("diagnostic interrupt not enabled by 40h");

   a_irq_gated: // R1
   assert property (DIAG_IRQ_REQ |-> $past(DIAG_IRQ_EN))
   else $error("interrupt request while disabled");

   a_wire_map: // R2
   assert property (wr_wire |-> ##2 WIRE_CHECK_EN == $past(PRM_DATA[3:0], 2))
   else $error("wire-break enables do not follow their bits");

   a_unit_sel: // R3
   assert property (wr_unit |-> ##2 TEMP_UNIT == $past(PRM_DATA[1:0], 2))
   else $error("temperature unit not taken from bits 1:0");

   a_mains_sel: // R4
   assert property (wr_mains && PRM_DATA[1:0] == `RTDPD_MAINS_60 |-> ##2 MAINS_REJ == `RTDPD_MAINS_60
      && (MOD_PARAM_ERR == $past(diag_bad || unit_bad)))
   else $error("60 Hz rejection code not applied");

   a_chan_off: // R6
   assert property (wr_fn && PRM_IDX[1:0] == 2'h0 && PRM_DATA == `RTDPD_FN_OFF
      |-> ##3 !CONV_EN[0])
   else $error("channel 0 still converting after off code");

   a_over_sticky: // R8
   assert property (ch_over[1] |=> DIAG_OVER[1] && CH_LED[1])
   else $error("overflow not recorded for channel 1");

   a_rsvd_zero: // R9
   assert property (PRM_IDX == `RTDPD_IDX_WIRE |=> PRM_RDATA[7:4] == 4'h0)
   else $error("reserved wire-break bits read back");

endmodule // rtdpd_top

// [pkg/rtdpd_cfg.svh]
// constants for the four-channel resistance and rtd input parameter decoder
// How it works
// R1: Diagnostic interrupt enabled only by byte 40h.
// R2: Wire-break byte bits 0-3 enable channels 0-3.
// R3: Unit bits 1:0 choose Celsius, Fahrenheit, Kelvin.
// R4: Suppression bits 1:0: 01 60 Hz, 10 50 Hz.
// R5: Function number picks sensor, wiring and scaling.
// R6: Function number FFh switches the channel off.
// R7: Head writes diag and wire-break only at stop.
// R8: Errors light channel LED and enter diagnostics.
// R9: Reserved bits ignored; unsupported codes flag error.
`ifndef RTDPD_CFG_SVH
`define RTDPD_CFG_SVH

// parameter byte indices, in record order
`define RTDPD_IDX_DIAG 3'h0
`define RTDPD_IDX_WIRE 3'h1
`define RTDPD_IDX_UNIT 3'h2
`define RTDPD_IDX_MAINS 3'h3

// reset values
`define RTDPD_RST_DIAG 8'h00
`define RTDPD_RST_WIRE 8'h00
`define RTDPD_RST_UNIT 8'h00
`define RTDPD_RST_MAINS 8'h02
`define RTDPD_RST_FN 8'h50

// field codes and masks
`define RTDPD_DIAG_ON 8'h40
`define RTDPD_DIAG_OFF 8'h00
`define RTDPD_WIRE_MASK 8'h0F
`define RTDPD_LOW2_MASK 8'h03
`define RTDPD_FN_OFF 8'hFF
`define RTDPD_UNIT_C 2'h0
`define RTDPD_UNIT_F 2'h1
`define RTDPD_UNIT_K 2'h2
`define RTDPD_MAINS_60 2'h1
`define RTDPD_MAINS_50 2'h2

// nominal limits in tenths of a degree Celsius
`define RTDPD_PT_HI 16'h2134
`define RTDPD_PT_LO 16'hF830
`define RTDPD_NI_HI 16'h09C4
`define RTDPD_NI_LO 16'hFDA8
`define RTDPD_NI120_HI 16'h0C80
`define RTDPD_NI120_LO 16'hFCE0

// unit conversion offsets, tenths
`define RTDPD_F_OFS 16'h0140
`define RTDPD_K_OFS 16'h0AAC

// resistance full-scale results
`define RTDPD_RAW_FULL 16'h7FFF
`define RTDPD_SCL_6000 16'h1770
`define RTDPD_SCL_30000 16'h7530
`define RTDPD_SCL_27648 16'h6C00

`endif

// [pkg/rtdpd_pkg.sv]
// types shared by the parameter decoder modules
package rtdpd_pkg;

   // sensor family and scaling class chosen by a function number
   typedef enum logic [2:0] {
      RTDPD_SENS_NONE,
      RTDPD_SENS_PT,
      RTDPD_SENS_NI,
      RTDPD_SENS_NI120,
      RTDPD_SENS_RAW,
      RTDPD_SENS_DEC,
      RTDPD_SENS_STD
   } rtdpd_sens_e;

   typedef logic [2:0] rtdpd_wires_t;

endpackage

// [verilog/rtdpd_chan.sv]
// one input channel: function number decode, range check and value scaling
`include "rtdpd_cfg.svh"
module rtdpd_chan (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] fn_code,
   input wire logic [1:0] unit,
   input wire logic raw_valid,
   input wire logic [15:0] raw_data,
   output logic conv_en,
   output logic param_err,
   output rtdpd_pkg::rtdpd_wires_t wires,
   output logic value_valid,
   output logic [15:0] value,
   output logic over,
   output logic under
);

   function automatic rtdpd_pkg::rtdpd_sens_e fn_sensor(input logic [7:0] f);
      case (f)
         8'h50, 8'h51, 8'h58, 8'h59, 8'h60, 8'h61: fn_sensor = rtdpd_pkg::RTDPD_SENS_PT;
         8'h52, 8'h53, 8'h5A, 8'h5B, 8'h62, 8'h63: fn_sensor = rtdpd_pkg::RTDPD_SENS_NI;
         8'h54, 8'h5C, 8'h64: fn_sensor = rtdpd_pkg::RTDPD_SENS_NI120;
         8'h70, 8'h71, 8'h72, 8'h78, 8'h79, 8'h7A, 8'h80, 8'h81, 8'h82: fn_sensor = rtdpd_pkg::RTDPD_SENS_RAW;
         8'h90, 8'h91, 8'h92, 8'h98, 8'h99, 8'h9A, 8'hA0, 8'hA1, 8'hA2: fn_sensor = rtdpd_pkg::RTDPD_SENS_DEC;
         8'hD0, 8'hD1, 8'hD2, 8'hD8, 8'hD9, 8'hDA, 8'hE0, 8'hE1, 8'hE2: fn_sensor = rtdpd_pkg::RTDPD_SENS_STD;
         default: fn_sensor = rtdpd_pkg::RTDPD_SENS_NONE;
      endcase
   endfunction

   // fraction of full scale times a result span, 15 bit fraction
   function automatic logic [15:0] scale(input logic [15:0] r, input logic [15:0] k);
      logic [31:0] p;
      p = r * k;
      scale = p[30:15];
   endfunction

   // R5: sensor and wiring
   wire rtdpd_pkg::rtdpd_sens_e sens = fn_sensor(fn_code);
   wire is_off = (fn_code == `RTDPD_FN_OFF);
   wire is_temp = (sens == rtdpd_pkg::RTDPD_SENS_PT) || (sens == rtdpd_pkg::RTDPD_SENS_NI)
      || (sens == rtdpd_pkg::RTDPD_SENS_NI120);
   wire four_wire = (fn_code[7:4] == 4'h6) || (fn_code[7:4] == 4'h8) || (fn_code[7:4] == 4'hA)
      || (fn_code[7:4] == 4'hE);
   wire rtdpd_pkg::rtdpd_wires_t wires_next = four_wire ? 3'h4 : (fn_code[3] ? 3'h3 : 3'h2);
   wire signed [15:0] c = raw_data;
   wire signed [15:0] hi = (sens == rtdpd_pkg::RTDPD_SENS_PT) ? `RTDPD_PT_HI :
      (sens == rtdpd_pkg::RTDPD_SENS_NI) ? `RTDPD_NI_HI : `RTDPD_NI120_HI;
   wire signed [15:0] lo = (sens == rtdpd_pkg::RTDPD_SENS_PT) ? `RTDPD_PT_LO :
      (sens == rtdpd_pkg::RTDPD_SENS_NI) ? `RTDPD_NI_LO : `RTDPD_NI120_LO;
   // signed multiply before divide keeps tenths exact to the truncation
   wire signed [19:0] c9 = 20'(c) * 20'sh00009;
   wire signed [19:0] c_f = c9 / 20'sh00005;
   wire [15:0] temp_val = (unit == `RTDPD_UNIT_F) ? (c_f[15:0] + `RTDPD_F_OFS) :
      (unit == `RTDPD_UNIT_K) ? (raw_data + `RTDPD_K_OFS) : raw_data;
   wire [15:0] dec_span = (fn_code[1:0] == 2'h2) ? `RTDPD_SCL_30000 : `RTDPD_SCL_6000;
   wire [15:0] res_val = (sens == rtdpd_pkg::RTDPD_SENS_DEC) ? scale(raw_data, dec_span) :
      (sens == rtdpd_pkg::RTDPD_SENS_STD) ? scale(raw_data, `RTDPD_SCL_27648) : raw_data;
   wire over_next = is_temp ? (c > hi) : (raw_data == `RTDPD_RAW_FULL);
   wire under_next = is_temp ? (c < lo) : raw_data[15];
   // R9: unsupported code
   wire perr_next = !is_off && (sens == rtdpd_pkg::RTDPD_SENS_NONE);
   // R6: off channel reports nothing
   wire report = raw_valid && !is_off && !perr_next;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         conv_en <= 1'b0;
         param_err <= 1'b0;
         wires <= 3'h2;
         value_valid <= 1'b0;
         value <= 16'h0000;
         over <= 1'b0;
         under <= 1'b0;
      end else begin
         conv_en <= !is_off && !perr_next;
         param_err <= perr_next;
         wires <= wires_next;
         value_valid <= report;
         over <= report && over_next;
         under <= report && under_next;
         if (report) begin
            value <= is_temp ? temp_val : res_val;
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_pt_celsius: // R5
   assert property (raw_valid && sens == rtdpd_pkg::RTDPD_SENS_PT && unit == `RTDPD_UNIT_C
      && c <= $signed(`RTDPD_PT_HI) && c >= $signed(`RTDPD_PT_LO)
      |=> value_valid && value == $past(raw_data) && !over && !under)
   else $error("pt celsius value not passed through");

   a_off_silent: // R6
   assert property (is_off |=> !value_valid && !param_err)
   else $error("switched off channel reported a value");

   a_bad_code: // R9
   assert property (!is_off && sens == rtdpd_pkg::RTDPD_SENS_NONE |=> param_err && !conv_en)
   else $error("unsupported function number not flagged");

endmodule // rtdpd_chan

// [testbench/rtdpd_head_model.sv]
// head module model: writes and reads parameter bytes over the backplane
module rtdpd_head_model (
   input wire logic clk,
   input wire logic stopped,
   output logic prm_wr,
   output logic [2:0] prm_idx,
   output logic [7:0] prm_data,
   input wire logic [7:0] prm_rdata
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      prm_wr = 1'b0;
      prm_idx = 3'h0;
      prm_data = 8'h00;
   end

   task automatic wr(input logic [2:0] idx, input logic [7:0] data);
      if (idx > 3'h1 || stopped) begin
         @(posedge clk);
         prm_wr <= 1'b1;
         prm_idx <= idx;
         prm_data <= data;
         @(posedge clk);
         prm_wr <= 1'b0;
         // released data no longer shows the last byte
         prm_data <= ~data;
      end
   endtask

   task automatic rd(input logic [2:0] idx, output logic [7:0] data);
      @(posedge clk);
      prm_idx <= idx;
      repeat (3) @(posedge clk);
      data = prm_rdata;
   endtask
endmodule // rtdpd_head_model

// [testbench/tb_top.sv]
// self-checking bench for the parameter decoder
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst_n, diag_clr, prm_wr, irq_en, irq_req, mod_err;
   logic [2:0] prm_idx;
   logic [7:0] prm_data, prm_rdata, b;
   logic [3:0] raw_valid, value_valid, conv_en, wire_en, d_par, d_ov, d_un, led;
   logic [3:0][15:0] raw_data, value;
   rtdpd_pkg::rtdpd_wires_t [3:0] ch_wires;
   logic [1:0] temp_unit, mains_rej;
   logic [15:0] v;
   logic seen;
   int n_fail, n_compared, n_irq;

   rtdpd_top u_dut (.CLK(clk), .RST_N(rst_n), .PRM_WR(prm_wr), .PRM_IDX(prm_idx), .PRM_DATA(prm_data),
      .PRM_RDATA(prm_rdata), .RAW_VALID(raw_valid), .RAW_DATA(raw_data), .DIAG_CLR(diag_clr),
      .VALUE_VALID(value_valid), .VALUE(value), .CONV_EN(conv_en), .CH_WIRES(ch_wires),
      .WIRE_CHECK_EN(wire_en), .TEMP_UNIT(temp_unit), .MAINS_REJ(mains_rej), .DIAG_IRQ_EN(irq_en),
      .DIAG_IRQ_REQ(irq_req), .MOD_PARAM_ERR(mod_err), .DIAG_PARAM(d_par), .DIAG_OVER(d_ov),
      .DIAG_UNDER(d_un), .CH_LED(led));
   rtdpd_head_model u_head (.clk(clk), .stopped(1'b1), .prm_wr(prm_wr), .prm_idx(prm_idx),
      .prm_data(prm_data), .prm_rdata(prm_rdata));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) begin
      if (irq_req === 1'b1) n_irq++;
   end

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // clear waits out the decode pipeline so a fixed error does not re-set
   task automatic fix();
      tick(4);
      diag_clr <= 1'b1;
      @(posedge clk);
      diag_clr <= 1'b0;
      tick(2);
   endtask
   task automatic conv(input int ch, input logic [15:0] d);
      seen = 1'b0;
      v = 16'h0000;
      @(posedge clk);
      raw_valid[ch] <= 1'b1;
      raw_data[ch] <= d;
      @(posedge clk);
      raw_valid[ch] <= 1'b0;
      raw_data[ch] <= ~d;
      // the valid pulse stands only from this edge to the next, so look before waiting
      repeat (3) begin
         #1;
         if (!seen && value_valid[ch] === 1'b1) begin
            seen = 1'b1;
            v = value[ch];
         end
         @(posedge clk);
      end
   endtask

   task automatic t_reset();
      logic [7:0] tab [8] = '{8'h00, 8'h00, 8'h00, 8'h02, 8'h50, 8'h50, 8'h50, 8'h50};
      for (int i = 0; i < 8; i++) begin
         u_head.rd(3'(i), b);
         chk("reset byte", 16'(tab[i]), 16'(b));
      end
      chk("reset conv", 16'h000F, 16'(conv_en));
      chk("reset unit/mains", 16'h0002, {12'h000, temp_unit, mains_rej});
      chk("reset wires", 16'h0002, 16'(ch_wires[3]));
   endtask
   task automatic t_diag();
      u_head.wr(3'h0, 8'h40);
      tick(3);
      chk("irq en on", 16'h0001, 16'(irq_en));
      u_head.wr(3'h0, 8'h41);
      tick(4);
      chk("bad diag", 16'h0002, {14'h0000, mod_err, irq_en});
      chk("bad diag conv", 16'h0000, 16'(conv_en));
      u_head.wr(3'h0, 8'h00);
      fix();
      chk("irq en off", 16'h0000, {14'h0000, mod_err, irq_en});
      chk("diag clr", 16'h0000, 16'(d_par));
   endtask
   task automatic t_wire();
      u_head.wr(3'h1, 8'hFA);
      tick(3);
      chk("wire en", 16'h000A, 16'(wire_en));
      u_head.rd(3'h1, b);
      chk("wire rsvd", 16'h000A, 16'(b));
   endtask
   task automatic t_unit();
      logic [15:0] ex [3] = '{16'h03E8, 16'h0848, 16'h0E94};
      for (int u = 0; u < 3; u++) begin
         u_head.wr(3'h2, 8'hFC | 8'(u));
         tick(3);
         chk("unit", 16'(u), 16'(temp_unit));
         conv(1, 16'h03E8);
         chk("temp value", ex[u], v);
      end
      u_head.wr(3'h2, 8'h03);
      tick(4);
      chk("unit 3", 16'h0001, 16'(mod_err));
      u_head.wr(3'h2, 8'h00);
      fix();
      for (int m = 1; m < 3; m++) begin
         u_head.wr(3'h3, 8'hFC | 8'(m));
         tick(3);
         chk("mains", 16'(m), 16'(mains_rej));
      end
   endtask
   task automatic t_fn();
      logic [7:0] fn [4] = '{8'h70, 8'h90, 8'h92, 8'hD0};
      logic [15:0] ex [4] = '{16'h4000, 16'h0BB8, 16'h3A98, 16'h3600};
      for (int i = 0; i < 4; i++) begin
         u_head.wr(3'h6, fn[i]);
         tick(4);
         conv(2, 16'h4000);
         chk("res value", ex[i], v);
      end
      u_head.wr(3'h5, 8'h58);
      u_head.wr(3'h6, 8'h60);
      tick(3);
      chk("wires", 16'h0043, {ch_wires[2], 1'b0, ch_wires[1]});
   endtask
   task automatic t_over();
      u_head.wr(3'h0, 8'h40);
      n_irq = 0;
      tick(3);
      conv(3, 16'h2135);
      tick(1);
      chk("over", 16'h0088, {d_ov[3], d_un[3], 2'h0, led[3], 3'h0});
      chk("over value", 16'h2135, v);
      chk("irq req", 16'h0001, 16'(n_irq));
      u_head.wr(3'h0, 8'h00);
      fix();
      conv(3, 16'hF82F);
      tick(1);
      chk("under", 16'h0048, {d_ov[3], d_un[3], 2'h0, led[3], 3'h0});
      chk("under value", 16'hF82F, v);
      chk("irq req off", 16'h0001, 16'(n_irq));
      fix();
   endtask
   task automatic t_off();
      u_head.wr(3'h4, 8'hFF);
      tick(4);
      chk("off conv", 16'h000E, 16'(conv_en));
      conv(0, 16'h0100);
      chk("off value", 16'h0000, 16'(seen));
      u_head.wr(3'h4, 8'h55);
      tick(4);
      chk("bad fn", 16'h0011, {d_par, led});
      u_head.wr(3'h4, 8'h50);
      fix();
      chk("bad fn clr", 16'h000F, {d_par, conv_en});
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   initial begin
      rst_n = 1'b0;
      diag_clr = 1'b0;
      raw_valid = 4'h0;
      raw_data = '0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_diag();
      t_wire();
      t_unit();
      t_fn();
      t_over();
      t_off();
      test_done();
   end
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      test_done();
   end
endmodule // tb_top
